/* File: hdl/msp_consts.vh */
// Constants of the multimode serial port with address recognition.
`ifndef MSP_CONSTS_VH
`define MSP_CONSTS_VH
// Register offsets.
`define MSP_OFS_CTRL 3'h0
`define MSP_OFS_BUF 3'h1
`define MSP_OFS_GADDR 3'h2
`define MSP_OFS_MASK 3'h3
`define MSP_OFS_PWR 3'h4
`define MSP_OFS_RSEL 3'h5
// Control register fields.
`define MSP_CTRL_MHI 7
`define MSP_CTRL_MLO 6
`define MSP_CTRL_AME 5
`define MSP_CTRL_REN 4
`define MSP_CTRL_TXNB 3
`define MSP_CTRL_RXNB 2
`define MSP_CTRL_TXF 1
`define MSP_CTRL_RXF 0
// Power control and rate source fields.
`define MSP_PWR_DBL 7
`define MSP_PWR_FSEL 6
`define MSP_RSEL_RSRC 5
`define MSP_RSEL_TSRC 4
// Reset values.
`define MSP_RST_BYTE 8'h00
// Mode codes.
`define MSP_MODE0 2'h0
`define MSP_MODE1 2'h1
`define MSP_MODE2 2'h2
`define MSP_MODE3 2'h3
// Timing counts: mode 0 cell in clocks, sub-bit positions in ticks, frame lengths in bits.
`define MSP_M0_LAST 4'hb
`define MSP_M0_HALF 4'h6
`define MSP_SUB_LAST 4'hf
`define MSP_SUB_MID 4'h7
`define MSP_BITS_M1 4'ha
`define MSP_BITS_M23 4'hb
`define MSP_BITS_M0 4'h8
`endif

/* File: hdl/msp_sync.v */
// Three-stage input synchroniser with agreement filter.
module msp_sync #(
  parameter RESET_VAL = 1'b1
) (
  input wire i_clk,
  input wire i_arst_n,
  input wire i_d,
  output wire o_q
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  reg q_r;

  // The output moves only once stages two and three agree, which hides single-cycle glitches.
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
      q_r <= RESET_VAL;
    end else begin
      s1_r <= i_d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q_r <= s3_r;
      end
    end
  end

  assign o_q = q_r;
endmodule // msp_sync

/* File: hdl/msp_top.v */
// Multimode serial port with frame error detection and address recognition.
//
// Chosen here: the register addresses and the plain strobed port.
`include "msp_consts.vh"
module msp_top (
  input wire I_CLK,
  input wire I_ARST_N,
  input wire [2:0] I_ADDR,
  input wire [7:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output wire [7:0] O_RDATA,
  input wire I_T1_OVF,
  input wire I_T2_OVF,
  input wire I_RXD,
  output wire O_RXD,
  output wire O_RXD_OE_N,
  output wire O_TXD,
  output wire O_IRQ
);
  reg [1:0] mode_r;
  reg amen_r;
  reg ren_r;
  reg txnb_r;
  reg rxnb_r;
  reg txf_r;
  reg rxf_r;
  reg ferr_r;
  reg fsel_r;
  reg dbl_r;
  reg tsrc_r;
  reg rsrc_r;
  reg [7:0] gaddr_r;
  reg [7:0] mask_r;
  reg [7:0] rxbuf_r;
  reg [7:0] rdata_r;
  reg t1_half_r;
  reg [1:0] pre_r;
  reg [3:0] ph_r;
  reg tx_busy_r;
  reg [10:0] tx_sh_r;
  reg [3:0] tx_cnt_r;
  reg [3:0] tx_sub_r;
  reg rx_busy_r;
  reg rx_first_r;
  reg [9:0] rx_sh_r;
  reg [3:0] rx_cnt_r;
  reg [3:0] rx_sub_r;
  reg rxd_prev_r;
  wire rxd_f;
  wire ctrl_wr;
  wire buf_wr;
  wire is_m0;
  wire t1_tick;
  wire m2_tick;
  wire tx_tick;
  wire rx_tick;
  wire tx_adv;
  wire tx_done;
  wire rx_fall;
  wire rx_start_a;
  wire rx_start_0;
  wire rx_samp;
  wire rx_done_a;
  wire rx_done_0;
  wire [9:0] rx_shifted;
  reg [7:0] rx_byte;
  reg rx_ninth;
  wire rx_stop;
  wire match;
  wire [7:0] bcast;
  wire accept;
  reg [7:0] rd_mux;
  reg txf_nxt;
  reg rxf_nxt;
  reg ferr_nxt;
  wire rx_t1_tick;

  // The pin is asynchronous, so every use of it goes through the filtered copy.
  msp_sync #(
    .RESET_VAL(1'b1)
  ) u_rxd_sync (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .i_d(I_RXD),
    .o_q(rxd_f)
  );

  assign ctrl_wr = I_WR && (I_ADDR == `MSP_OFS_CTRL);
  assign buf_wr = I_WR && (I_ADDR == `MSP_OFS_BUF);
  assign is_m0 = (mode_r == `MSP_MODE0);

  // Timer1 overflow is halved unless the rate doubling bit is set.
  assign t1_tick = I_T1_OVF && (dbl_r || t1_half_r);
  // Mode 2 sixteenth-bit tick every four clocks, or every two when doubled.
  assign m2_tick = dbl_r ? pre_r[0] : (pre_r == 2'h3);
  // Outside mode 2 each direction picks its own source, so the two rates may differ.
  assign tx_tick = (mode_r == `MSP_MODE2) ? m2_tick : (tsrc_r ? I_T2_OVF : t1_tick);
  assign rx_tick = (mode_r == `MSP_MODE2) ? m2_tick : (rsrc_r ? I_T2_OVF : rx_t1_tick);
  // Mode 3 shares the mode 1 timer path; only the frame length differs.
  assign rx_t1_tick = t1_tick;

  // Mode 0 advances once per twelve clocks; others after sixteen ticks.
  assign tx_adv = tx_busy_r && (is_m0 ? (ph_r == `MSP_M0_LAST)
                  : (tx_tick && (tx_sub_r == `MSP_SUB_LAST)));
  assign tx_done = tx_adv && (tx_cnt_r == 4'h1);

  assign rx_fall = rxd_prev_r && !rxd_f;
  assign rx_start_a = !is_m0 && ren_r && rx_fall && !rx_busy_r;
  assign rx_start_0 = is_m0 && ren_r && !rxf_r && !rx_busy_r && !tx_busy_r && !buf_wr;
  assign rx_samp = rx_busy_r && (is_m0 ? (ph_r == `MSP_M0_LAST)
                   : (rx_tick && (rx_sub_r == `MSP_SUB_MID)));
  assign rx_shifted = {rxd_f, rx_sh_r[9:1]};
  assign rx_done_a = rx_samp && !is_m0 && !rx_first_r && (rx_cnt_r == 4'h1);
  assign rx_done_0 = rx_samp && is_m0 && (rx_cnt_r == 4'h1);

  // Received fields sit at different places of the shifter per frame length.
  always @* begin
    case (mode_r)
      `MSP_MODE0: begin
        rx_byte = rx_shifted[9:2];
        rx_ninth = 1'b0;
      end
      `MSP_MODE1: begin
        rx_byte = rx_shifted[8:1];
        rx_ninth = rx_shifted[9];
      end
      default: begin
        rx_byte = rx_shifted[7:0];
        rx_ninth = rx_shifted[8];
      end
    endcase
  end
  assign rx_stop = rx_shifted[9];

  // Only mask ones take part; the broadcast form compares only its ones.
  assign bcast = gaddr_r | mask_r;
  assign match = (((rx_byte ^ gaddr_r) & mask_r) == 8'h00)
                 || (((rx_byte ^ bcast) & bcast) == 8'h00);
  // A held receive flag blocks the new byte so unread data is not overwritten.
  assign accept = !rxf_r && (!amen_r || ((mode_r == `MSP_MODE1) ? (rx_stop && match)
                  : (rx_ninth && match)));

  // Hardware set wins over a software clear landing in the same cycle.
  always @* begin
    txf_nxt = ctrl_wr ? I_WDATA[`MSP_CTRL_TXF] : txf_r;
    rxf_nxt = ctrl_wr ? I_WDATA[`MSP_CTRL_RXF] : rxf_r;
    ferr_nxt = (ctrl_wr && fsel_r) ? I_WDATA[`MSP_CTRL_MHI] : ferr_r;
    if (tx_done) begin
      txf_nxt = 1'b1;
    end
    // Mode 0 frames bypass the address filter entirely.
    if ((rx_done_a && accept) || rx_done_0) begin
      rxf_nxt = 1'b1;
    end
    if (rx_done_a && !rx_stop) begin
      ferr_nxt = 1'b1;
    end
  end

  always @* begin
    case (I_ADDR)
      `MSP_OFS_CTRL: rd_mux = {(fsel_r ? ferr_r : mode_r[1]), mode_r[0], amen_r, ren_r,
                               txnb_r, rxnb_r, txf_r, rxf_r};
      `MSP_OFS_BUF: rd_mux = rxbuf_r;
      `MSP_OFS_GADDR: rd_mux = gaddr_r;
      `MSP_OFS_MASK: rd_mux = mask_r;
      `MSP_OFS_PWR: rd_mux = {dbl_r, fsel_r, 6'h00};
      `MSP_OFS_RSEL: rd_mux = {2'h0, rsrc_r, tsrc_r, 4'h0};
      default: rd_mux = 8'h00;
    endcase
  end

  // There is no idle gating here: the port runs on every clock edge.
  always @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      mode_r <= `MSP_MODE0;
      amen_r <= 1'b0;
      ren_r <= 1'b0;
      txnb_r <= 1'b0;
      rxnb_r <= 1'b0;
      txf_r <= 1'b0;
      rxf_r <= 1'b0;
      ferr_r <= 1'b0;
      fsel_r <= 1'b0;
      dbl_r <= 1'b0;
      tsrc_r <= 1'b0;
      rsrc_r <= 1'b0;
      gaddr_r <= `MSP_RST_BYTE;
      mask_r <= `MSP_RST_BYTE;
      rxbuf_r <= `MSP_RST_BYTE;
      rdata_r <= `MSP_RST_BYTE;
    end else begin
      rdata_r <= I_RD ? rd_mux : 8'h00;
      txf_r <= txf_nxt;
      rxf_r <= rxf_nxt;
      ferr_r <= ferr_nxt;
      if (ctrl_wr) begin
        if (!fsel_r) begin
          mode_r[1] <= I_WDATA[`MSP_CTRL_MHI];
        end
        mode_r[0] <= I_WDATA[`MSP_CTRL_MLO];
        amen_r <= I_WDATA[`MSP_CTRL_AME];
        ren_r <= I_WDATA[`MSP_CTRL_REN];
        txnb_r <= I_WDATA[`MSP_CTRL_TXNB];
      end
      if (I_WR && (I_ADDR == `MSP_OFS_GADDR)) begin
        gaddr_r <= I_WDATA;
      end
      if (I_WR && (I_ADDR == `MSP_OFS_MASK)) begin
        mask_r <= I_WDATA;
      end
      if (I_WR && (I_ADDR == `MSP_OFS_PWR)) begin
        dbl_r <= I_WDATA[`MSP_PWR_DBL];
        fsel_r <= I_WDATA[`MSP_PWR_FSEL];
      end
      if (I_WR && (I_ADDR == `MSP_OFS_RSEL)) begin
        rsrc_r <= I_WDATA[`MSP_RSEL_RSRC];
        tsrc_r <= I_WDATA[`MSP_RSEL_TSRC];
      end
      if (rx_done_0 || (rx_done_a && accept)) begin
        rxbuf_r <= rx_byte;
      end
      if (rx_done_a && accept) begin
        rxnb_r <= (mode_r == `MSP_MODE1) ? rx_stop : rx_ninth;
      end
      // A software write of the ninth bit loses to a received one in the same cycle.
      if (ctrl_wr && !(rx_done_a && accept)) begin
        rxnb_r <= I_WDATA[`MSP_CTRL_RXNB];
      end
    end
  end

  // Rate dividers and mode 0 phase counter.
  always @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      t1_half_r <= 1'b0;
      pre_r <= 2'h0;
      ph_r <= 4'h0;
      rxd_prev_r <= 1'b1;
    end else begin
      rxd_prev_r <= rxd_f;
      pre_r <= pre_r + 2'h1;
      if (I_T1_OVF) begin
        t1_half_r <= !t1_half_r;
      end
      // A buffer write restarts the cell so the shift clock always opens low.
      if (!is_m0 || (!tx_busy_r && !rx_busy_r) || (ph_r == `MSP_M0_LAST) || buf_wr) begin
        ph_r <= 4'h0;
      end else begin
        ph_r <= ph_r + 4'h1;
      end
    end
  end

  // Transmitter.
  always @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      tx_busy_r <= 1'b0;
      tx_sh_r <= 11'h7ff;
      tx_cnt_r <= 4'h0;
      tx_sub_r <= 4'h0;
    end else if (buf_wr) begin
      // A write during a frame restarts it with the new byte.
      tx_busy_r <= 1'b1;
      tx_sub_r <= 4'h0;
      case (mode_r)
        `MSP_MODE0: begin
          tx_sh_r <= {3'h7, I_WDATA};
          tx_cnt_r <= `MSP_BITS_M0;
        end
        `MSP_MODE1: begin
          tx_sh_r <= {2'h3, I_WDATA, 1'b0};
          tx_cnt_r <= `MSP_BITS_M1;
        end
        default: begin
          tx_sh_r <= {1'b1, txnb_r, I_WDATA, 1'b0};
          tx_cnt_r <= `MSP_BITS_M23;
        end
      endcase
    end else if (tx_busy_r) begin
      if (!is_m0 && tx_tick) begin
        tx_sub_r <= tx_sub_r + 4'h1;
      end
      if (tx_adv) begin
        tx_sh_r <= {1'b1, tx_sh_r[10:1]};
        tx_cnt_r <= tx_cnt_r - 4'h1;
        if (tx_done) begin
          tx_busy_r <= 1'b0;
        end
      end
    end
  end

  // Receiver; in mode 0 the buffer write takes the shared pins over.
  always @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rx_busy_r <= 1'b0;
      rx_first_r <= 1'b0;
      rx_sh_r <= 10'h000;
      rx_cnt_r <= 4'h0;
      rx_sub_r <= 4'h0;
    end else if ((is_m0 && buf_wr) || !ren_r) begin
      rx_busy_r <= 1'b0;
    end else if (rx_start_0) begin
      rx_busy_r <= 1'b1;
      rx_first_r <= 1'b0;
      rx_cnt_r <= `MSP_BITS_M0;
    end else if (rx_start_a) begin
      rx_busy_r <= 1'b1;
      rx_first_r <= 1'b1;
      rx_sub_r <= 4'h0;
      rx_cnt_r <= (mode_r == `MSP_MODE1) ? `MSP_BITS_M1 : `MSP_BITS_M23;
    end else if (rx_busy_r) begin
      if (!is_m0 && rx_tick) begin
        rx_sub_r <= rx_sub_r + 4'h1;
      end
      if (rx_samp) begin
        rx_cnt_r <= rx_cnt_r - 4'h1;
        rx_first_r <= 1'b0;
        if (!rx_first_r) begin
          rx_sh_r <= rx_shifted;
        end
        // A start bit that is high again at mid-bit was noise.
        if ((rx_first_r && rxd_f) || (rx_cnt_r == 4'h1)) begin
          rx_busy_r <= 1'b0;
        end
      end
    end
  end

  // Mode 0 drives data on the receive pin and the shift clock on transmit.
  assign O_RXD_OE_N = !(is_m0 && tx_busy_r);
  assign O_RXD = (is_m0 && tx_busy_r) ? tx_sh_r[0] : 1'b1;
  assign O_TXD = is_m0 ? !((tx_busy_r || rx_busy_r) && (ph_r < `MSP_M0_HALF))
                 : (tx_busy_r ? tx_sh_r[0] : 1'b1);
  // Both flags stay up until software clears them, so the request is a level.
  assign O_IRQ = txf_r || rxf_r;
  assign O_RDATA = rdata_r;
endmodule // msp_top

/* File: tb/msp_props.sv */
// Port assertions for the multimode serial port.
`include "msp_consts.vh"
module msp_props (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic [2:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] O_RDATA,
  input wire logic I_T1_OVF,
  input wire logic I_T2_OVF,
  input wire logic I_RXD,
  input wire logic O_RXD,
  input wire logic O_RXD_OE_N,
  input wire logic O_TXD,
  input wire logic O_IRQ
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);
  property p_rd_idle; !$past(I_RD) |-> O_RDATA == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_tx_start; I_WR && I_ADDR == `MSP_OFS_BUF |=> !O_TXD; endproperty
  a_tx_start: assert property (p_tx_start) else $error("buffer write did not start");
  property p_irq_or; I_RD && I_ADDR == `MSP_OFS_CTRL |=> (|O_RDATA[1:0]) == $past(O_IRQ);
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq not flag or");
  property p_irq_sw; $fell(O_IRQ) |-> $past(I_WR && I_ADDR == `MSP_OFS_CTRL); endproperty
  a_irq_sw: assert property (p_irq_sw) else $error("flag dropped by hardware");
  property p_m0_cell; $fell(O_TXD) && !O_RXD_OE_N |-> !O_TXD [*6] ##1 O_TXD [*6]; endproperty
  a_m0_cell: assert property (p_m0_cell) else $error("shift clock cell wrong");
  property p_m0_data; $changed(O_RXD) && !O_RXD_OE_N && $past(!O_RXD_OE_N) |-> $fell(O_TXD);
  endproperty
  a_m0_data: assert property (p_m0_data) else $error("shift data moved off clock");
  property p_m0_oe; $fell(O_RXD_OE_N) |-> !O_TXD; endproperty
  a_m0_oe: assert property (p_m0_oe) else $error("shift clock not low at start");
  property p_rxd_rel; O_RXD_OE_N |-> O_RXD; endproperty
  a_rxd_rel: assert property (p_rxd_rel) else $error("released data pin not high");
  property p_start; $fell(O_TXD) && O_RXD_OE_N |-> !O_TXD [*6]; endproperty
  a_start: assert property (p_start) else $error("start bit too short");
endmodule // msp_props

/* File: tb/msp_peer.sv */
// Serial peer that sends frames to the port and captures its frames.
module msp_peer (
  input wire logic i_clk,
  input wire logic i_txd,
  output logic o_rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_rxd = 1'b1;
  // The line idles high between frames, as an asynchronous peer would leave it.
  task automatic send(input logic [10:0] f, input int nb, input int per);
    for (int i = 0; i < nb; i++) begin
      o_rxd <= f[i];
      repeat (per) @(posedge i_clk);
    end
    o_rxd <= 1'b1;
  endtask
  // Bits are taken mid-cell so that small edge skew does no harm.
  task automatic recv(output logic [10:0] f, input int nb, input int per);
    f = '1;
    @(negedge i_txd);
    repeat (per / 2) @(posedge i_clk);
    for (int i = 0; i < nb; i++) begin
      f[i] = i_txd;
      repeat (per) @(posedge i_clk);
    end
  endtask
endmodule // msp_peer

/* File: tb/msp_top_tb.sv */
// Self-checking bench for the multimode serial port.
module msp_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic I_CLK = 0, I_ARST_N = 0, I_WR = 0, I_RD = 0, ovf = 0;
  logic [2:0] I_ADDR = 3'h0;
  logic [7:0] I_WDATA = 8'h00, r, d, ga, mk;
  logic [10:0] f, ef;
  wire [7:0] O_RDATA;
  wire O_RXD, O_RXD_OE_N, O_TXD, O_IRQ, peer_rxd;
  wire pin = O_RXD_OE_N ? peer_rxd : O_RXD;
  int err_total = 0, compares = 0, cyc = 0, md, sm, n9, st, ok;
  int tm[5] = '{1, 2, 2, 3, 3};
  int tper[5] = '{32, 32, 64, 32, 32};
  logic [7:0] ts[5] = '{8'h30, 8'h00, 8'h00, 8'h10, 8'h00};
  logic [7:0] tp[5] = '{8'h80, 8'h80, 8'h00, 8'h80, 8'h80};
  msp_top u_msp_top (.I_CLK, .I_ARST_N, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA,
    .I_T1_OVF(ovf), .I_T2_OVF(ovf), .I_RXD(pin), .O_RXD, .O_RXD_OE_N, .O_TXD, .O_IRQ);
  msp_peer u_msp_peer (.i_clk(I_CLK), .i_txd(O_TXD), .o_rxd(peer_rxd));
  always #10 I_CLK = ~I_CLK;
  // Overflows every second clock give 32-clock bits on timer2 or doubled timer1.
  always @(posedge I_CLK) begin
    ovf <= ~ovf;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      give_verdict();
    end
  end
  task give_verdict;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] v);
    I_ADDR <= a;
    I_WDATA <= v;
    I_WR <= 1'b1;
    @(posedge I_CLK);
    I_WR <= 1'b0;
    @(posedge I_CLK);
  endtask
  task rd(input logic [2:0] a, output logic [7:0] v);
    I_ADDR <= a;
    I_RD <= 1'b1;
    @(posedge I_CLK);
    I_RD <= 1'b0;
    #1 v = O_RDATA;
    @(posedge I_CLK);
  endtask
  function logic [10:0] fr(int m, logic [7:0] b, logic n, logic s);
    return m == 1 ? {1'b1, s, b, 1'b0} : {s, n, b, 1'b0};
  endfunction
  function logic hit(logic [7:0] b);
    return ((b ^ ga) & mk) == 8'h00 || (b & (ga | mk)) == (ga | mk);
  endfunction
  task rxc(input int m, input int s2, input logic [7:0] b, input logic n, input logic s);
    wr(3'h0, {m[1:0], s2[0], 5'h10});
    u_msp_peer.send(fr(m, b, n, s), m == 1 ? 10 : 11, 32);
    rd(3'h0, r);
    ok = !s2 || (hit(b) && (m == 1 ? s : n));
    chk(r & 8'h01, ok ? 8'h01 : 8'h00);
    if (ok) begin
      chk(r & 8'h04, (m == 1 ? s : n) ? 8'h04 : 8'h00);
      rd(3'h1, d);
      chk(d, b);
    end
    wr(3'h0, 8'h00);
  endtask
  initial begin
    ok = $urandom(28007);
    repeat (20) @(posedge I_CLK);
    I_ARST_N <= 1'b1;
    @(posedge I_CLK);
    wr(3'h7, 8'hff);
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], r);
      chk(r, 8'h00);
    end
    ga = 8'($urandom);
    mk = 8'($urandom);
    wr(3'h2, ga);
    wr(3'h3, mk);
    rd(3'h2, r);
    chk(r, ga);
    rd(3'h3, r);
    chk(r, mk);
    for (int i = 0; i < 5; i++) begin
      md = tm[i];
      d = 8'($urandom);
      n9 = $urandom % 2;
      wr(3'h4, tp[i]);
      wr(3'h5, ts[i]);
      wr(3'h0, {md[1:0], 2'h0, n9[0], 3'h0});
      ef = fr(md, d, n9[0], 1'b1);
      fork
        wr(3'h1, d);
        u_msp_peer.recv(f, md == 1 ? 10 : 11, tper[i]);
      join
      chk(f[7:0], ef[7:0]);
      chk({5'h0, f[10:8]}, {5'h0, ef[10:8]});
      rd(3'h0, r);
      chk(r & 8'h02, 8'h02);
      wr(3'h0, 8'h00);
    end
    d = 8'($urandom);
    fork
      wr(3'h1, d);
      for (int k = 0; k < 8; k++) begin
        @(posedge O_TXD);
        f[k] = O_RXD;
      end
    join
    chk(f[7:0], d);
    repeat (8) @(posedge I_CLK);
    rd(3'h0, r);
    chk(r & 8'h02, 8'h02);
    wr(3'h5, 8'h20);
    wr(3'h4, 8'hc0);
    wr(3'h0, 8'h50);
    u_msp_peer.send(fr(1, 8'h5a, 1'b0, 1'b0), 10, 32);
    rd(3'h0, r);
    chk(r & 8'h80, 8'h80);
    u_msp_peer.send(fr(1, 8'ha5, 1'b0, 1'b1), 10, 32);
    rd(3'h0, r);
    chk(r & 8'h80, 8'h80);
    wr(3'h0, 8'h40);
    rd(3'h0, r);
    chk(r, 8'h40);
    wr(3'h4, 8'h00);
    wr(3'h0, 8'h10);
    repeat (110) @(posedge I_CLK);
    rd(3'h0, r);
    chk(r & 8'h01, 8'h01);
    rd(3'h1, d);
    chk(d, 8'hff);
    wr(3'h4, 8'h80);
    for (int i = 0; i < 12; i++) begin
      md = 1 + $urandom % 3;
      sm = i < 3 ? 1 : $urandom % 2;
      case ($urandom % 3)
        0: d = ga;
        1: d = ga | mk;
        default: d = 8'($urandom);
      endcase
      n9 = $urandom % 2;
      st = (md == 1 && sm) ? $urandom % 2 : 1;
      rxc(md, sm, d, n9[0], st[0]);
    end
    give_verdict();
  end
endmodule // msp_top_tb
bind msp_top msp_props u_msp_props (.I_CLK, .I_ARST_N, .I_ADDR, .I_WDATA, .I_WR, .I_RD,
  .O_RDATA, .I_T1_OVF, .I_T2_OVF, .I_RXD, .O_RXD, .O_RXD_OE_N, .O_TXD, .O_IRQ);
